//--- verilog/mcgw_pkg.sv
package mcgw_pkg;
    // register port addresses (model-specific register numbers, chosen locally)
    localparam logic [1:0] ADDR_CAPABILITIES = 2'h0;
    localparam logic [1:0] ADDR_GLOBAL_STATUS = 2'h1;
    localparam logic [1:0] ADDR_GLOBAL_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_WATCHDOG = 2'h3;

    // capabilities fields
    localparam int BANK_COUNT_MSB = 7;
    localparam int CONTROL_PRESENT_BIT = 8;

    // global status fields
    localparam int RESTART_VALID_BIT = 0;
    localparam int ERROR_VALID_BIT = 1;
    localparam int IN_PROGRESS_BIT = 2;

    // watchdog control fields
    localparam int WD_ENABLE_BIT = 0;
    localparam int WD_BASE_LSB = 1;
    localparam int WD_BASE_MSB = 2;
    localparam int WD_SELECT_LSB = 3;
    localparam int WD_SELECT_MSB = 6;
    localparam int WD_CTRL_WIDTH = 7;
    localparam logic [1:0] BASE_MILLI = 2'h0;
    localparam logic [1:0] BASE_MICRO = 2'h1;

    // time base in cycles at 25 MHz
    localparam int CLOCK_HZ = 25000000;
    localparam int MICRO_PER_SEC = 1000000;
    localparam int MILLI_PER_SEC = 1000;
    localparam int MICRO_CYCLES = CLOCK_HZ / MICRO_PER_SEC;
    localparam int MILLI_CYCLES = CLOCK_HZ / MILLI_PER_SEC;
    localparam int PRESCALE_WIDTH = 15;
    localparam int UNIT_WIDTH = 14;
    localparam logic [PRESCALE_WIDTH-1:0] MILLI_TICK_MAX = PRESCALE_WIDTH'(MILLI_CYCLES - 1);
    localparam logic [PRESCALE_WIDTH-1:0] MICRO_TICK_MAX = PRESCALE_WIDTH'(MICRO_CYCLES - 1);
    localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_STEP = 15'h1;
    localparam logic [UNIT_WIDTH-1:0] UNIT_STEP = 14'h1;

    // period in time-base units for each count-select code
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL0 = 14'hfff;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL1 = 14'h7ff;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL2 = 14'h3ff;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL3 = 14'h1ff;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL4 = 14'hff;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL5 = 14'h7f;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL6 = 14'h3f;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL7 = 14'h1f;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL8 = 14'h1fff;
    localparam logic [UNIT_WIDTH-1:0] COUNT_SEL9 = 14'h3fff;

    // register field widths
    localparam int STATUS_WIDTH = 3;
    localparam int BANK_WIDTH = 8;

    localparam logic [63:0] RESET_ZERO = 64'h0;
endpackage

//--- verilog/mcgw_top.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - capabilities low byte reports bank count
// - presence bit shows global control exists
// - restart-valid set only when restart reliable
// - error-pointer-valid set when instruction caused error
// - in-progress set on every machine check
// - second check while in progress: shutdown
// - global control enables banks; ones enable all implemented banks
// - some sources may log while disabled
// - watchdog raises check on missed completion
// - count restarts on each instruction completion
// - counter holds during halt or stop-grant
// - enable bit gates counting and signalling
// - time base: 00b millisecond, 01b microsecond
// - period equals count-select value times base
// - count-select table gives period values
// - registers reached by model register instructions
module mcgw_top #(
    parameter logic [7:0] BANK_COUNT = 8'h04,
    parameter logic CONTROL_PRESENT = 1'b1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // model register read/write port
    input wire logic i_reg_read,
    input wire logic i_reg_write,
    input wire logic [1:0] i_reg_addr,
    input wire logic [63:0] i_reg_wdata,
    output logic [63:0] o_reg_rdata,
    // core events
    input wire logic i_instr_done,
    input wire logic i_halted,
    input wire logic i_stop_grant,
    input wire logic i_bank_error,
    input wire logic i_error_restartable,
    input wire logic i_error_at_pointer,
    // machine check outputs
    output logic o_machine_check,
    output logic o_shutdown,
    output logic o_watchdog_expired,
    output logic [7:0] o_bank_enable
);
    // configuration registers
    logic [mcgw_pkg::STATUS_WIDTH-1:0] status_q;
    logic [mcgw_pkg::STATUS_WIDTH-1:0] status_d;
    logic [mcgw_pkg::BANK_WIDTH-1:0] bank_en_q;
    logic [mcgw_pkg::BANK_WIDTH-1:0] bank_en_d;
    logic [mcgw_pkg::WD_CTRL_WIDTH-1:0] wd_ctrl_q;
    logic [mcgw_pkg::WD_CTRL_WIDTH-1:0] wd_ctrl_d;

    // watchdog counter
    logic [mcgw_pkg::PRESCALE_WIDTH-1:0] pre_q;
    logic [mcgw_pkg::PRESCALE_WIDTH-1:0] pre_d;
    logic [mcgw_pkg::UNIT_WIDTH-1:0] unit_q;
    logic [mcgw_pkg::UNIT_WIDTH-1:0] unit_d;

    // machine-check state
    logic mc_q;
    logic mc_d;
    logic shut_q;
    logic shut_d;
    logic wdx_q;
    logic wdx_d;

    // read data
    logic [63:0] rdata_q;
    logic [63:0] rdata_d;

    // decoded controls
    logic [1:0] base;
    logic [3:0] sel;
    logic [mcgw_pkg::UNIT_WIDTH-1:0] limit;
    logic [mcgw_pkg::PRESCALE_WIDTH-1:0] tick_max;
    logic sel_legal;
    logic base_legal;
    logic running;
    logic tick;
    logic last_unit;
    logic core_active;
    logic expire;
    logic bank_error_seen;
    logic check_event;
    logic in_progress;
    logic accept_event;
    logic [mcgw_pkg::BANK_WIDTH-1:0] bank_mask;
    logic [mcgw_pkg::BANK_WIDTH-1:0] bank_wr;
    logic [mcgw_pkg::STATUS_WIDTH-1:0] status_sw;

    assign base = wd_ctrl_q[mcgw_pkg::WD_BASE_MSB:mcgw_pkg::WD_BASE_LSB];
    assign sel = wd_ctrl_q[mcgw_pkg::WD_SELECT_MSB:mcgw_pkg::WD_SELECT_LSB];

    // banks above the implemented count never enable, whatever software
    // writes, so an all-ones write enables exactly the implemented banks
    for (genvar i = 0; i < mcgw_pkg::BANK_WIDTH; i++) begin : g_bank_mask
        assign bank_mask[i] = (i < int'(BANK_COUNT));
    end

    // count-select decode; codes above nine have no period, so the
    // watchdog stays idle rather than guess one
    always_comb begin
        sel_legal = 1'b1;
        unique case (sel)
            4'h0: limit = mcgw_pkg::COUNT_SEL0;
            4'h1: limit = mcgw_pkg::COUNT_SEL1;
            4'h2: limit = mcgw_pkg::COUNT_SEL2;
            4'h3: limit = mcgw_pkg::COUNT_SEL3;
            4'h4: limit = mcgw_pkg::COUNT_SEL4;
            4'h5: limit = mcgw_pkg::COUNT_SEL5;
            4'h6: limit = mcgw_pkg::COUNT_SEL6;
            4'h7: limit = mcgw_pkg::COUNT_SEL7;
            4'h8: limit = mcgw_pkg::COUNT_SEL8;
            4'h9: limit = mcgw_pkg::COUNT_SEL9;
            default: begin
                limit = '0;
                sel_legal = 1'b0;
            end
        endcase
    end

    // time-base decode; reserved codes have no unit and keep the
    // watchdog idle
    always_comb begin
        base_legal = 1'b1;
        unique case (base)
            mcgw_pkg::BASE_MILLI: tick_max = mcgw_pkg::MILLI_TICK_MAX;
            mcgw_pkg::BASE_MICRO: tick_max = mcgw_pkg::MICRO_TICK_MAX;
            default: begin
                tick_max = '0;
                base_legal = 1'b0;
            end
        endcase
    end

    assign running = wd_ctrl_q[mcgw_pkg::WD_ENABLE_BIT] && sel_legal && base_legal;
    assign tick = (pre_q == tick_max);
    assign last_unit = (unit_q == limit - mcgw_pkg::UNIT_STEP);

    // halt and stop-grant freeze the count, a completion restarts it
    assign core_active = !i_instr_done && !i_halted && !i_stop_grant;
    assign expire = running && core_active && tick && last_unit;

    // watchdog counter; one prescaler serves both bases, and a completion
    // discards the partial unit so every period is whole units
    always_comb begin
        pre_d = pre_q;
        unit_d = unit_q;
        if (!running) begin
            pre_d = '0;
            unit_d = '0;
        end else if (i_instr_done || expire) begin
            pre_d = '0;
            unit_d = '0;
        end else if (i_halted || i_stop_grant) begin
            pre_d = pre_q;
            unit_d = unit_q;
        end else if (tick) begin
            pre_d = '0;
            unit_d = unit_q + mcgw_pkg::UNIT_STEP;
        end else begin
            pre_d = pre_q + mcgw_pkg::PRESCALE_STEP;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pre_q <= '0;
            unit_q <= '0;
        end else begin
            pre_q <= pre_d;
            unit_q <= unit_d;
        end
    end

    // global control write: only implemented banks take the value
    assign bank_wr = i_reg_wdata[mcgw_pkg::BANK_WIDTH-1:0] & bank_mask;
    assign status_sw = i_reg_wdata[mcgw_pkg::STATUS_WIDTH-1:0];

    // a bank error reports only when any global bank enable is set; logging in the
    // banks themselves may go on regardless and is outside this block
    assign bank_error_seen = i_bank_error && |bank_en_q;
    assign check_event = expire || bank_error_seen;
    assign in_progress = status_q[mcgw_pkg::IN_PROGRESS_BIT];
    assign accept_event = check_event && !shut_q;

    // software writes to the configuration registers
    always_comb begin
        bank_en_d = bank_en_q;
        wd_ctrl_d = wd_ctrl_q;
        status_d = status_q;
        if (i_reg_write) begin
            unique case (i_reg_addr)
                mcgw_pkg::ADDR_CAPABILITIES: begin
                    // write ignored, the register is fixed
                end
                mcgw_pkg::ADDR_GLOBAL_STATUS: begin
                    status_d = status_sw;
                end
                mcgw_pkg::ADDR_GLOBAL_CONTROL: begin
                    // without the global control register the enables stay at reset
                    if (CONTROL_PRESENT) begin
                        bank_en_d = bank_wr;
                    end
                end
                mcgw_pkg::ADDR_WATCHDOG: begin
                    wd_ctrl_d = i_reg_wdata[mcgw_pkg::WD_CTRL_WIDTH-1:0];
                end
            endcase
        end
        // hardware set beats a same-cycle software clear
        if (accept_event && !in_progress) begin
            status_d[mcgw_pkg::IN_PROGRESS_BIT] = 1'b1;
            // a watchdog expiry means the pointer is not at a completed
            // instruction, so neither pointer flag is claimed
            status_d[mcgw_pkg::RESTART_VALID_BIT] = !expire && i_error_restartable;
            status_d[mcgw_pkg::ERROR_VALID_BIT] = !expire && i_error_at_pointer;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            status_q <= '0;
            bank_en_q <= '0;
            wd_ctrl_q <= '0;
        end else begin
            status_q <= status_d;
            bank_en_q <= bank_en_d;
            wd_ctrl_q <= wd_ctrl_d;
        end
    end

    // machine-check signalling; shutdown is sticky until reset
    always_comb begin
        mc_d = 1'b0;
        shut_d = shut_q;
        wdx_d = expire;
        if (accept_event) begin
            // a second event while one is in progress cannot be reported,
            // so the core is told to stop instead
            if (in_progress) begin
                shut_d = 1'b1;
            end else begin
                mc_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mc_q <= 1'b0;
            shut_q <= 1'b0;
            wdx_q <= 1'b0;
        end else begin
            mc_q <= mc_d;
            shut_q <= shut_d;
            wdx_q <= wdx_d;
        end
    end

    // read data is registered and stands until the next read; reserved
    // and unused bits read as zero
    always_comb begin
        rdata_d = rdata_q;
        if (i_reg_read) begin
            rdata_d = mcgw_pkg::RESET_ZERO;
            unique case (i_reg_addr)
                mcgw_pkg::ADDR_CAPABILITIES: begin
                    rdata_d[mcgw_pkg::BANK_COUNT_MSB:0] = BANK_COUNT;
                    rdata_d[mcgw_pkg::CONTROL_PRESENT_BIT] = CONTROL_PRESENT;
                end
                mcgw_pkg::ADDR_GLOBAL_STATUS: begin
                    rdata_d[mcgw_pkg::STATUS_WIDTH-1:0] = status_q;
                end
                mcgw_pkg::ADDR_GLOBAL_CONTROL: begin
                    rdata_d[mcgw_pkg::BANK_WIDTH-1:0] = bank_en_q;
                end
                mcgw_pkg::ADDR_WATCHDOG: begin
                    rdata_d[mcgw_pkg::WD_CTRL_WIDTH-1:0] = wd_ctrl_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_q <= mcgw_pkg::RESET_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // every output comes straight from a flip-flop
    assign o_reg_rdata = rdata_q;
    assign o_machine_check = mc_q;
    assign o_shutdown = shut_q;
    assign o_watchdog_expired = wdx_q;
    assign o_bank_enable = bank_en_q;
endmodule
`default_nettype wire

//--- test/mcgw_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcgw_core_model #(
    parameter int GAP = 100
) (
    // clock
    input wire logic i_core_clk,
    // control and completion
    input wire logic i_run,
    output logic o_instr_done = 1'b0
);
    int cnt_q = 0;
    // gap stays far below the shortest period, so a running core never trips the watchdog
    always @(posedge i_core_clk) begin
        cnt_q <= (!i_run || cnt_q == GAP - 1) ? 0 : cnt_q + 1;
        o_instr_done <= i_run && cnt_q == GAP - 1;
    end
endmodule
`default_nettype wire

//--- test/mcgw_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module mcgw_top_sva #(
    parameter logic [7:0] BANK_COUNT = 8'h04,
    parameter logic CONTROL_PRESENT = 1'b1
) (
    // watched ports
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_read,
    input wire logic i_reg_write,
    input wire logic [1:0] i_reg_addr,
    input wire logic [63:0] i_reg_wdata,
    input wire logic [63:0] o_reg_rdata,
    input wire logic i_instr_done,
    input wire logic i_halted,
    input wire logic i_stop_grant,
    input wire logic o_machine_check,
    input wire logic o_shutdown,
    input wire logic o_watchdog_expired,
    input wire logic [7:0] o_bank_enable
);
    localparam logic [7:0] MSK = 8'((16'h1 << BANK_COUNT) - 16'h1);
    logic [6:0] wd_q;
    wire logic idle = !wd_q[0] || wd_q[2] || (wd_q[6:3] > 4'h9);
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wd_q <= 7'h0;
        end else if (i_reg_write && i_reg_addr == mcgw_pkg::ADDR_WATCHDOG) begin
            wd_q <= i_reg_wdata[6:0];
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_cap; i_reg_read && i_reg_addr == mcgw_pkg::ADDR_CAPABILITIES
        |=> o_reg_rdata == {55'h0, CONTROL_PRESENT, BANK_COUNT}; endproperty
    a_cap: assert property (p_cap) else $error("cap value");
    property p_hold; !i_reg_read |=> $stable(o_reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_ben; CONTROL_PRESENT && i_reg_write && i_reg_addr == mcgw_pkg::ADDR_GLOBAL_CONTROL
        |=> o_bank_enable == ($past(i_reg_wdata[7:0]) & MSK); endproperty
    a_ben: assert property (p_ben) else $error("bank enable");
    property p_pulse; o_machine_check |=> !o_machine_check; endproperty
    a_pulse: assert property (p_pulse) else $error("check pulse");
    property p_shut; o_shutdown |=> o_shutdown && !o_machine_check; endproperty
    a_shut: assert property (p_shut) else $error("shutdown");
    property p_quiet; idle && $past(idle) && $past(idle, 2) |-> !o_watchdog_expired; endproperty
    a_quiet: assert property (p_quiet) else $error("idle expiry");
    property p_freeze; (i_halted || i_stop_grant) [*3] |-> !o_watchdog_expired; endproperty
    a_freeze: assert property (p_freeze) else $error("frozen expiry");
    property p_done; i_instr_done |-> ##2 !o_watchdog_expired; endproperty
    a_done: assert property (p_done) else $error("restart");
endmodule
bind mcgw_top mcgw_top_sva #(.BANK_COUNT(BANK_COUNT), .CONTROL_PRESENT(CONTROL_PRESENT)) u_sva (
    .i_core_clk, .i_rst_n, .i_reg_read, .i_reg_write, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_instr_done, .i_halted, .i_stop_grant, .o_machine_check, .o_shutdown, .o_watchdog_expired,
    .o_bank_enable);
`default_nettype wire

//--- test/mcgw_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mcgw_top_tb;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, done, halt = 0, stop = 0, be = 0, rs = 0, ap = 0;
    logic run = 0, mc, shut, wexp;
    logic [1:0] addr = 2'h0;
    logic [63:0] wd = 64'h0, rdata;
    logic [63:0] q[3] = '{64'h3a, 64'h3d, 64'h51};
    logic [7:0] ben;
    int errors = 0, n_tests = 0, n_mc = 0, n_exp = 0, cyc = 0, c;
    mcgw_top DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_read(rd), .i_reg_write(wr),
        .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_instr_done(done),
        .i_halted(halt), .i_stop_grant(stop), .i_bank_error(be), .i_error_restartable(rs),
        .i_error_at_pointer(ap), .o_machine_check(mc), .o_shutdown(shut),
        .o_watchdog_expired(wexp), .o_bank_enable(ben));
    mcgw_core_model CORE (.i_core_clk(clk), .i_run(run), .o_instr_done(done));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic complete_run();
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(negedge clk) begin
        cyc++;
        if (mc) n_mc++;
        if (wexp) n_exp++;
        if (cyc > 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input string nm, input logic [63:0] s, input logic [63:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wreg(input logic [1:0] a, input logic [63:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [1:0] a, input logic [63:0] e, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(nm, rdata, e);
    endtask
    task automatic err(input logic r, input logic p);
        @(posedge clk);
        be <= 1'b1;
        rs <= r;
        ap <= p;
        @(posedge clk);
        be <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rreg(mcgw_pkg::ADDR_CAPABILITIES, 64'h104, "cap");
        wreg(mcgw_pkg::ADDR_CAPABILITIES, 64'h0);
        rreg(mcgw_pkg::ADDR_CAPABILITIES, 64'h104, "cap_wr");
        wreg(mcgw_pkg::ADDR_GLOBAL_CONTROL, 64'hffffffffffffffff);
        rreg(mcgw_pkg::ADDR_GLOBAL_CONTROL, 64'hf, "ctrl");
        check("ben", 64'(ben), 64'h0f);
        err(1'b1, 1'b1);
        rreg(mcgw_pkg::ADDR_GLOBAL_STATUS, 64'h7, "st_a");
        wreg(mcgw_pkg::ADDR_GLOBAL_STATUS, 64'h0);
        err(1'b0, 1'b0);
        rreg(mcgw_pkg::ADDR_GLOBAL_STATUS, 64'h4, "st_b");
        check("mc_n", 64'(n_mc), 64'h2);
        wreg(mcgw_pkg::ADDR_GLOBAL_STATUS, 64'h0);
        foreach (q[i]) begin
            wreg(mcgw_pkg::ADDR_WATCHDOG, q[i]);
            repeat (900) @(posedge clk);
        end
        check("exp_off", 64'(n_exp), 64'h0);
        run <= 1'b1;
        wreg(mcgw_pkg::ADDR_WATCHDOG, 64'h3b);
        repeat (2000) @(posedge clk);
        check("exp_run", 64'(n_exp), 64'h0);
        run <= 1'b0;
        halt <= 1'b1;
        repeat (1000) @(posedge clk);
        halt <= 1'b0;
        stop <= 1'b1;
        repeat (1000) @(posedge clk);
        stop <= 1'b0;
        check("exp_frz", 64'(n_exp), 64'h0);
        // disable then enable, so the period is timed from a cleared count
        wreg(mcgw_pkg::ADDR_WATCHDOG, 64'h3a);
        wreg(mcgw_pkg::ADDR_WATCHDOG, 64'h3b);
        c = 0;
        while (wexp !== 1'b1 && c < 2000) begin
            @(negedge clk);
            c++;
        end
        check("wd_period", 64'(c >= 774 && c <= 779), 64'h1);
        repeat (3) @(posedge clk);
        check("mc_wd", 64'(n_mc), 64'h3);
        rreg(mcgw_pkg::ADDR_GLOBAL_STATUS, 64'h4, "st_wd");
        err(1'b1, 1'b1);
        check("shut", 64'(shut), 64'h1);
        check("mc_sd", 64'(n_mc), 64'h3);
        complete_run();
    end
endmodule
`default_nettype wire
